//--- logic/tlic_top.sv
`timescale 1ns/10ps
module tlic_top
  import tlic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_req_pin0_n,
  input wire logic ext_req_pin1_n,
  input wire logic [3:0] ext_req_pin25_n,
  input wire logic timer0_ovf_set,
  input wire logic timer1_ovf_set,
  input wire logic timer2_ovf_set,
  input wire logic timer2_ext_set,
  input wire logic serial0_rx_set,
  input wire logic serial0_tx_set,
  input wire logic serial1_rx_set,
  input wire logic serial1_tx_set,
  input wire logic wdog_timeout,
  input wire logic instr_last_cycle,
  input wire logic instr_blocks_irq,
  input wire logic reti_exec,
  input wire logic [15:0] core_pc,
  output logic call_req,
  output logic [15:0] call_vector,
  output logic [15:0] push_pc,
  output logic call_done
);
  logic [1:0] phase_q;
  logic sample;
  logic [7:0] ie_q, ip_q, eie_q, eip_q;
  logic it0_q, it1_q, ie0_q, ie1_q, tf0_q, tf1_q;
  logic [3:0] iex_q, hc_q;
  logic tf2_q, timer2_ext_flag_q, ri0_q, ti0_q, ri1_q, ti1_q, wdog_irq_flag_q;
  logic [1:0] insvc_q;
  tlic_state_t state_q;
  logic [2:0] mc_cnt_q;
  logic [3:0] sel_q;
  logic sel_hi_q;
  logic [15:0] vec_q, pc_q;
  logic req_out_q, done_q;
  logic ap_wr_q, ap_rd_q;
  logic [11:0] ap_adr_q;
  logic [31:0] rdata_q;
  logic fall0, fall1;
  logic [3:0] fall25;
  logic [11:0] src_req, en_vec, pr_vec, req_hi, req_lo;
  logic any_hi, any_lo;
  logic [3:0] idx_hi, idx_lo;
  logic take, take_hi;
  logic [3:0] take_idx;
  logic clr_ext0, clr_ext1, clr_t0, clr_t1;
  logic [3:0] clr_ext25;
  logic wr;
  logic [7:0] wd;
  logic ap_valid;

  // Four clocks form one machine cycle; pins are sampled in the third phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign sample = (phase_q == tlic_sample_phase);

  tlic_edge_det u_edge0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(sample),
    .pin_n(ext_req_pin0_n),
    .fall(fall0)
  );

  tlic_edge_det u_edge1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(sample),
    .pin_n(ext_req_pin1_n),
    .fall(fall1)
  );

  for (genvar g = 0; g < 4; g++) begin : g_edge
    tlic_edge_det u_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .sample(sample),
      .pin_n(ext_req_pin25_n[g]),
      .fall(fall25[g])
    );
  end

  // Bus address phase is captured; writes land in the data phase.
  assign ap_valid = hsel & hready & htrans[1];
  assign wr = ap_wr_q;
  assign wd = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_adr_q <= 12'h000;
    end else begin
      ap_wr_q <= ap_valid & hwrite;
      ap_rd_q <= ap_valid & ~hwrite;
      ap_adr_q <= haddr[11:0];
    end
  end

  // Enable and priority registers; reset leaves every source disabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ie_q <= tlic_ie_rst;
      eie_q <= tlic_eie_rst;
      ip_q <= tlic_ip_rst;
      eip_q <= tlic_eip_rst;
      it0_q <= 1'b0;
      it1_q <= 1'b0;
      hc_q <= 4'h0;
    end else if (wr) begin
      case (ap_adr_q)
        tlic_adr_ie: ie_q <= wd;
        tlic_adr_ip: ip_q <= {1'b0, wd[6:0]};
        tlic_adr_eie: eie_q <= {3'h0, wd[4:0]};
        tlic_adr_eip: eip_q <= {3'h0, wd[4:0]};
        tlic_adr_misc: begin
          it0_q <= wd[0];
          it1_q <= wd[1];
        end
        tlic_adr_timer2_mode_reg: hc_q <= wd[7:4];
        default: ;
      endcase
    end
  end

  // Clears caused by vectoring; hardware sets win over software clears.
  assign clr_ext0 = take & (take_idx == 4'(tlic_s_ext0)) & it0_q;
  assign clr_ext1 = take & (take_idx == 4'(tlic_s_ext1)) & it1_q;
  assign clr_t0 = take & (take_idx == 4'(tlic_s_tmr0));
  assign clr_t1 = take & (take_idx == 4'(tlic_s_tmr1));
  for (genvar g = 0; g < 4; g++) begin : g_clr
    assign clr_ext25[g] = take & (take_idx == 4'(tlic_s_ext2 + g)) & hc_q[g];
  end

  // Timer control flags: level mode makes the flag follow the sampled pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ie0_q <= 1'b0;
      ie1_q <= 1'b0;
      tf0_q <= 1'b0;
      tf1_q <= 1'b0;
    end else begin
      if (wr && ap_adr_q == tlic_adr_timer_ctrl_reg) begin
        ie0_q <= wd[1];
        ie1_q <= wd[3];
        tf0_q <= wd[5];
        tf1_q <= wd[7];
      end else begin
        if (clr_ext0) ie0_q <= 1'b0;
        if (clr_ext1) ie1_q <= 1'b0;
        if (clr_t0) tf0_q <= 1'b0;
        if (clr_t1) tf1_q <= 1'b0;
      end
      if (it0_q && fall0) ie0_q <= 1'b1;
      else if (!it0_q && sample) ie0_q <= ~ext_req_pin0_n;
      if (it1_q && fall1) ie1_q <= 1'b1;
      else if (!it1_q && sample) ie1_q <= ~ext_req_pin1_n;
      if (timer0_ovf_set) tf0_q <= 1'b1;
      if (timer1_ovf_set) tf1_q <= 1'b1;
    end
  end

  // Flags for pins 2 to 5, timer 2, serial ports and watchdog.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iex_q <= 4'h0;
      tf2_q <= 1'b0;
      timer2_ext_flag_q <= 1'b0;
      ri0_q <= 1'b0;
      ti0_q <= 1'b0;
      ri1_q <= 1'b0;
      ti1_q <= 1'b0;
      wdog_irq_flag_q <= 1'b0;
    end else begin
      // Pins 2 to 5: a software write or a vectoring clear loses to a fresh edge.
      // Without the hardware-clear bit these flags stay set until software acts.
      if (wr && ap_adr_q == tlic_adr_stat) begin
        tf2_q <= wd[0];
        timer2_ext_flag_q <= wd[1];
        ri0_q <= wd[2];
        ti0_q <= wd[3];
        ri1_q <= wd[4];
        ti1_q <= wd[5];
      end
      if (wr && ap_adr_q == tlic_adr_wdog_ctrl_reg) wdog_irq_flag_q <= wd[tlic_wdog_irq_flag_bit];
      iex_q <= (wr && ap_adr_q == tlic_adr_ext_flag_reg ? wd[7:4] : iex_q & ~clr_ext25) |
        fall25;
      if (timer2_ovf_set) tf2_q <= 1'b1;
      if (timer2_ext_set) timer2_ext_flag_q <= 1'b1;
      if (serial0_rx_set) ri0_q <= 1'b1;
      if (serial0_tx_set) ti0_q <= 1'b1;
      if (serial1_rx_set) ri1_q <= 1'b1;
      if (serial1_tx_set) ti1_q <= 1'b1;
      if (wdog_timeout) wdog_irq_flag_q <= 1'b1;
    end
  end

  // Request, enable and priority vectors in tie-break order.
  assign src_req = {wdog_irq_flag_q, iex_q[3], iex_q[2], iex_q[1], iex_q[0], ri1_q | ti1_q,
    tf2_q | timer2_ext_flag_q, ri0_q | ti0_q, tf1_q, ie1_q, tf0_q, ie0_q};
  assign en_vec = {eie_q[tlic_eie_wd_bit], eie_q[3:0], ie_q[6:0]} &
    {12{ie_q[tlic_ie_glb_bit]}};
  assign pr_vec = {eip_q[4:0], ip_q[6:0]};
  assign req_hi = src_req & en_vec & pr_vec;
  assign req_lo = src_req & en_vec & ~pr_vec;

  // Each level is resolved on its own, so a high request never waits behind a
  // low one that happens to sit earlier in the fixed order.
  tlic_prio_enc u_enc_hi (
    .req(req_hi),
    .any(any_hi),
    .idx(idx_hi)
  );

  tlic_prio_enc u_enc_lo (
    .req(req_lo),
    .any(any_lo),
    .idx(idx_lo)
  );

  // The poll looks at live flags only, so a denied request is forgotten.
  always_comb begin
    take_hi = 1'b0;
    take_idx = 4'h0;
    take = 1'b0;
    if (state_q == tlic_idle && sample && instr_last_cycle && !instr_blocks_irq &&
        !reti_exec) begin
      if (any_hi && !insvc_q[1]) begin
        take = 1'b1;
        take_hi = 1'b1;
        take_idx = idx_hi;
      end else if (any_lo && insvc_q == 2'b00) begin
        take = 1'b1;
        take_idx = idx_lo;
      end
    end
  end

  // Call sequencer: four machine cycles, vector and pushed address held throughout.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= tlic_idle;
      mc_cnt_q <= 3'h0;
      sel_q <= 4'h0;
      sel_hi_q <= 1'b0;
      vec_q <= 16'h0000;
      pc_q <= 16'h0000;
      req_out_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        tlic_idle: begin
          if (take) begin
            state_q <= tlic_call;
            mc_cnt_q <= 3'h0;
            sel_q <= take_idx;
            sel_hi_q <= take_hi;
            vec_q <= tlic_vec[take_idx];
            pc_q <= core_pc;
            req_out_q <= 1'b1;
          end
        end
        tlic_call: begin
          if (phase_q == tlic_sample_phase - 2'h1) begin
            if (mc_cnt_q == tlic_call_mcs - 3'h1) begin
              state_q <= tlic_idle;
              req_out_q <= 1'b0;
              done_q <= 1'b1;
            end else begin
              mc_cnt_q <= mc_cnt_q + 3'h1;
            end
          end
        end
        default: state_q <= tlic_idle;
      endcase
    end
  end

  // In-service bits per level; a plain return never reaches here.
  // A return always closes the higher open level first, which matches nesting,
  // because a low service can only be preempted by a high one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insvc_q <= 2'b00;
    end else if (take) begin
      insvc_q[take_hi ? 1 : 0] <= 1'b1;
    end else if (reti_exec) begin
      if (insvc_q[1]) insvc_q[1] <= 1'b0;
      else insvc_q[0] <= 1'b0;
    end
  end

  // Read data decoded from the address phase, registered for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      case (haddr[11:0])
        tlic_adr_ie: rdata_q <= {24'h0, ie_q};
        tlic_adr_ip: rdata_q <= {24'h0, ip_q};
        tlic_adr_eie: rdata_q <= {24'h0, eie_q};
        tlic_adr_eip: rdata_q <= {24'h0, eip_q};
        tlic_adr_timer_ctrl_reg: rdata_q <= {24'h0, tf1_q, 1'b0, tf0_q, 1'b0, ie1_q, it1_q, ie0_q, it0_q};
        tlic_adr_ext_flag_reg: rdata_q <= {24'h0, iex_q, 4'h0};
        tlic_adr_timer2_mode_reg: rdata_q <= {24'h0, hc_q, 4'h0};
        tlic_adr_misc: rdata_q <= {24'h0, 2'h0, insvc_q, 2'h0, it1_q, it0_q};
        tlic_adr_wdog_ctrl_reg: rdata_q <= {24'h0, 4'h0, wdog_irq_flag_q, 3'h0};
        tlic_adr_stat: rdata_q <= {24'h0, 2'h0, ti1_q, ri1_q, ti0_q, ri0_q, timer2_ext_flag_q, tf2_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Every register access completes without wait states and never errors, so
  // ready and response are fixed; software cannot stall the poll this way.
  // The trade is that unmapped offsets read as zero instead of reporting faults.
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign call_req = req_out_q;
  assign call_vector = vec_q;
  assign push_pc = pc_q;
  assign call_done = done_q;
endmodule // tlic_top

//--- logic/tlic_pkg.sv
// Behaviour
// - Twelve sources, two levels; each has flag, enable, priority bit, fixed vector.
// - Pins 0 and 1 in edge mode set flag on high sample then low sample.
// - Edge-mode flags of pins 0 and 1 clear when the core vectors there.
// - Level mode: flag follows pin, not cleared on entry, re-requests if still low.
// - Pins 2 to 5 are falling-edge only, cleared by software by default.
// - Hardware-clear enable bits for sources 2 to 5 clear flag on entry.
// - Timer 0 and 1 overflow flags request and clear on vectoring.
// - Timer 2 request is OR of overflow and external flag; no hardware clear.
// - Watchdog flag at bit 3 requests only with extended enable bit 4.
// - Each serial port requests from OR of receive and transmit done flags.
// - Software may write every flag; a set flag requests like hardware.
// - Each source gated by its enable; global enable blocks all requests.
// - Sources assignable high or low; low never preempts high service.
// - Same-level ties resolved ext0,t0,ext1,t1,ser0,t2,ser1,ext2..5,wdog.
// - Flags sampled, polled and resolved within every machine cycle.
// - Call only with no equal/higher service, last cycle, no blocking instruction.
// - Denied requests are not remembered; each poll is new.
// - Call pushes program counter, not status word, then loads the vector.
// - Vectors 0003h,000Bh,0013h,001Bh,0023h,002Bh,003Bh,0043h,004Bh,0053h,005Bh,0063h.
// - Return-from-interrupt ends current service; plain return leaves state unchanged.
// - Reset clears the enable registers, disabling every source.
// - Pins sampled in phase C3; timer flags set at C3, polled next cycle.
// - Vector call takes four machine cycles, five minimum from flag to routine.
package tlic_pkg;
  localparam int unsigned tlic_n_src = 12;
  localparam logic [3:0] tlic_clk_per_mc = 4'h4;
  localparam logic [1:0] tlic_sample_phase = 2'h2;
  localparam logic [2:0] tlic_call_mcs = 3'h4;
  localparam logic [11:0] tlic_adr_ie = 12'h000;
  localparam logic [11:0] tlic_adr_ip = 12'h004;
  localparam logic [11:0] tlic_adr_eie = 12'h008;
  localparam logic [11:0] tlic_adr_eip = 12'h00c;
  localparam logic [11:0] tlic_adr_timer_ctrl_reg = 12'h010;
  localparam logic [11:0] tlic_adr_ext_flag_reg = 12'h014;
  localparam logic [11:0] tlic_adr_timer2_mode_reg = 12'h018;
  localparam logic [11:0] tlic_adr_misc = 12'h01c;
  localparam logic [11:0] tlic_adr_wdog_ctrl_reg = 12'h020;
  localparam logic [11:0] tlic_adr_stat = 12'h024;
  localparam logic [7:0] tlic_ie_rst = 8'h00;
  localparam logic [7:0] tlic_ip_rst = 8'h00;
  localparam logic [7:0] tlic_eie_rst = 8'h00;
  localparam logic [7:0] tlic_eip_rst = 8'h00;
  localparam int unsigned tlic_ie_glb_bit = 7;
  localparam int unsigned tlic_wdog_irq_flag_bit = 3;
  localparam int unsigned tlic_eie_wd_bit = 4;
  // Source indices in fixed tie-break order, index 0 is served first.
  localparam int unsigned tlic_s_ext0 = 0;
  localparam int unsigned tlic_s_tmr0 = 1;
  localparam int unsigned tlic_s_ext1 = 2;
  localparam int unsigned tlic_s_tmr1 = 3;
  localparam int unsigned tlic_s_ser0 = 4;
  localparam int unsigned tlic_s_tmr2 = 5;
  localparam int unsigned tlic_s_ser1 = 6;
  localparam int unsigned tlic_s_ext2 = 7;
  localparam int unsigned tlic_s_wdog = 11;
  localparam logic [15:0] tlic_vec [tlic_n_src] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063};
  typedef enum logic [1:0] {tlic_idle, tlic_call} tlic_state_t;
endpackage

//--- logic/tlic_edge_det.sv
`timescale 1ns/10ps
// Falling-edge detector on machine-cycle samples of one request pin.
module tlic_edge_det (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample,
  input wire logic pin_n,
  output logic fall
);
  logic prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b1;
    end else if (sample) begin
      prev_q <= pin_n;
    end
  end

  assign fall = sample & prev_q & ~pin_n;
endmodule // tlic_edge_det

//--- logic/tlic_prio_enc.sv
`timescale 1ns/10ps
// Picks the lowest-index active request of one level.
module tlic_prio_enc (
  input wire logic [11:0] req,
  output logic any,
  output logic [3:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule // tlic_prio_enc

//--- sim/tlic_assertions.sv
`timescale 1ns/10ps
module tlic_assertions
  import tlic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic instr_last_cycle,
  input wire logic instr_blocks_irq,
  input wire logic reti_exec,
  input wire logic [15:0] core_pc,
  input wire logic call_req,
  input wire logic [15:0] call_vector,
  input wire logic [15:0] push_pc,
  input wire logic call_done
);
  logic wr_q;
  logic ea_q;
  logic [11:0] adr_q;
  logic [4:0] len_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of the global enable, so a call can be tied to what software last wrote.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      adr_q <= 12'h000;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      adr_q <= haddr[11:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ea_q <= 1'b0;
    end else if (wr_q && hready && adr_q == tlic_adr_ie) begin
      ea_q <= hwdata[tlic_ie_glb_bit];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_q <= 5'h00;
    end else begin
      len_q <= call_req ? len_q + 5'h01 : 5'h00;
    end
  end
  property p_vec_legal;
    call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0063 && call_vector != 16'h0033;
  endproperty
  a_vec_legal: assert property (p_vec_legal)
    else $error("call vector off the table");
  property p_call_len;
    $fell(call_req) |-> len_q inside {5'h0f, 5'h10};
  endproperty
  a_call_len: assert property (p_call_len)
    else $error("call length wrong");
  property p_fell_done;
    $fell(call_req) |-> call_done;
  endproperty
  a_fell_done: assert property (p_fell_done)
    else $error("no done at call end");
  property p_done;
    call_done |-> !call_req ##1 !call_done;
  endproperty
  a_done: assert property (p_done)
    else $error("done not a lone pulse");
  property p_hold;
    call_req && $past(call_req) |-> $stable(call_vector) && $stable(push_pc);
  endproperty
  a_hold: assert property (p_hold)
    else $error("call outputs moved");
  property p_push;
    $rose(call_req) |-> push_pc == $past(core_pc);
  endproperty
  a_push: assert property (p_push)
    else $error("pushed pc wrong");
  property p_cond;
    $rose(call_req) |-> $past(instr_last_cycle) && !$past(instr_blocks_irq) && !$past(reti_exec);
  endproperty
  a_cond: assert property (p_cond)
    else $error("call at a refused poll");
  property p_global;
    $rose(call_req) |-> $past(ea_q);
  endproperty
  a_global: assert property (p_global)
    else $error("call with global enable off");
endmodule // tlic_assertions
bind tlic_top tlic_assertions i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .instr_last_cycle, .instr_blocks_irq, .reti_exec, .core_pc, .call_req, .call_vector,
  .push_pc, .call_done);

//--- sim/tlic_core_model.sv
`timescale 1ns/10ps
module tlic_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hold,
  input wire logic blk,
  input wire logic ret_req,
  output logic instr_last_cycle,
  output logic instr_blocks_irq,
  output logic reti_exec,
  output logic [15:0] core_pc
);
  logic [1:0] ph_q;
  // Holding models a long instruction, so every poll is refused until release.
  assign instr_last_cycle = !hold;
  assign instr_blocks_irq = blk;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 2'h0;
      core_pc <= 16'h0100;
      reti_exec <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      reti_exec <= ret_req;
      if (ph_q == 2'h3) begin
        core_pc <= core_pc + 16'h0001;
      end
    end
  end
endmodule // tlic_core_model

//--- sim/two_level_vectored_irq_controller_tb_top.sv
`timescale 1ns/10ps
module two_level_vectored_irq_controller_tb_top;
  import tlic_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hold, blk, ret_req;
  logic ext_req_pin0_n, ext_req_pin1_n, instr_last_cycle, instr_blocks_irq, reti_exec;
  logic call_req, call_done;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] ext_req_pin25_n;
  logic [8:0] p;
  logic [15:0] core_pc, call_vector, push_pc;
  logic [31:0] haddr, hwdata, hrdata, r;
  int miscompares, n_compared, i, k;
  tlic_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .ext_req_pin0_n, .ext_req_pin1_n, .ext_req_pin25_n,
    .timer0_ovf_set(p[0]), .timer1_ovf_set(p[1]), .timer2_ovf_set(p[2]), .timer2_ext_set(p[3]),
    .serial0_rx_set(p[4]), .serial0_tx_set(p[5]), .serial1_rx_set(p[6]), .serial1_tx_set(p[7]),
    .wdog_timeout(p[8]), .instr_last_cycle, .instr_blocks_irq, .reti_exec, .core_pc, .call_req,
    .call_vector, .push_pc, .call_done);
  tlic_core_model i_core (.hclk, .hresetn, .hold, .blk, .ret_req, .instr_last_cycle,
    .instr_blocks_irq, .reti_exec, .core_pc);
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    miscompares++;
    $display("MISMATCH wait expected event seen none");
    results();
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) tmo();
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk("rdata", {24'h0, e}, {24'h0, r[7:0] & m});
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic take(input int s);
    int n;
    n = 0;
    while (call_req !== 1'b1 && n < 400) begin @(negedge hclk); n++; end
    chk("call_vector", {16'h0, tlic_vec[s]}, {16'h0, call_vector});
    while (call_done !== 1'b1 && n < 400) begin @(negedge hclk); n++; end
    if (n >= 400) tmo();
    @(posedge hclk);
  endtask
  task automatic nocall();
    int c;
    c = 0;
    repeat (48) begin @(negedge hclk); if (call_req !== 1'b0) c++; end
    chk("call_cycles", 32'h0, c);
  endtask
  task automatic ret();
    @(posedge hclk);
    ret_req <= 1'b1;
    @(posedge hclk);
    ret_req <= 1'b0;
  endtask
  initial begin
    {hsel, hwrite, ret_req, blk, p, htrans, haddr, hwdata} = '0;
    {hold, ext_req_pin0_n, ext_req_pin1_n, ext_req_pin25_n} = '1;
    hsize = 3'h2;
    hresetn = 1'b0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h86b3));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(tlic_adr_ie, 8'hff, tlic_ie_rst);
    rd(tlic_adr_eie, 8'h1f, tlic_eie_rst);
    rd(12'h03c, 8'hff, 8'h00);
    k = $urandom_range(127, 0);
    bus(tlic_adr_ip, 1'b1, k[7:0]);
    rd(tlic_adr_ip, 8'h7f, k[7:0]);
    bus(tlic_adr_ip, 1'b1, 8'h00);
    p <= 9'h1ff;
    @(posedge hclk);
    p <= 9'h000;
    rd(tlic_adr_timer_ctrl_reg, 8'ha0, 8'ha0);
    rd(tlic_adr_stat, 8'h3f, 8'h3f);
    rd(tlic_adr_wdog_ctrl_reg, 8'h08, 8'h08);
    bus(tlic_adr_timer_ctrl_reg, 1'b1, 8'h00);
    bus(tlic_adr_stat, 1'b1, 8'h00);
    $display("test registers done");
    bus(tlic_adr_misc, 1'b1, 8'h03);
    bus(tlic_adr_timer2_mode_reg, 1'b1, 8'hf0);
    bus(tlic_adr_ie, 1'b1, 8'hff);
    bus(tlic_adr_eie, 1'b1, 8'h1f);
    bus(tlic_adr_timer_ctrl_reg, 1'b1, 8'haa);
    bus(tlic_adr_ext_flag_reg, 1'b1, 8'hf0);
    bus(tlic_adr_stat, 1'b1, 8'h15);
    hold <= 1'b0;
    for (i = 0; i < 12; i++) begin
      take(i);
      case (i)
        4: bus(tlic_adr_stat, 1'b1, 8'h11);
        5: bus(tlic_adr_stat, 1'b1, 8'h10);
        6: bus(tlic_adr_stat, 1'b1, 8'h00);
        11: bus(tlic_adr_wdog_ctrl_reg, 1'b1, 8'h00);
        default: ;
      endcase
      ret();
    end
    $display("test order done");
    hold <= 1'b1;
    bus(tlic_adr_eip, 1'b1, 8'h10);
    bus(tlic_adr_stat, 1'b1, 8'h04);
    bus(tlic_adr_wdog_ctrl_reg, 1'b1, 8'h08);
    hold <= 1'b0;
    take(tlic_s_wdog);
    nocall();
    bus(tlic_adr_wdog_ctrl_reg, 1'b1, 8'h00);
    ret();
    take(tlic_s_ser0);
    bus(tlic_adr_wdog_ctrl_reg, 1'b1, 8'h08);
    take(tlic_s_wdog);
    bus(tlic_adr_wdog_ctrl_reg, 1'b1, 8'h00);
    ret();
    nocall();
    bus(tlic_adr_stat, 1'b1, 8'h00);
    ret();
    bus(tlic_adr_eip, 1'b1, 8'h00);
    $display("test levels done");
    bus(tlic_adr_ie, 1'b1, 8'h01);
    bus(tlic_adr_timer_ctrl_reg, 1'b1, 8'h02);
    nocall();
    blk <= 1'b1;
    bus(tlic_adr_ie, 1'b1, 8'h85);
    nocall();
    bus(tlic_adr_timer_ctrl_reg, 1'b1, 8'h00);
    blk <= 1'b0;
    nocall();
    $display("test gating done");
    ext_req_pin0_n <= 1'b0;
    take(tlic_s_ext0);
    ext_req_pin0_n <= 1'b1;
    ret();
    bus(tlic_adr_misc, 1'b1, 8'h01);
    ext_req_pin1_n <= 1'b0;
    take(tlic_s_ext1);
    ret();
    take(tlic_s_ext1);
    ext_req_pin1_n <= 1'b1;
    repeat (8) @(posedge hclk);
    ret();
    nocall();
    bus(tlic_adr_eie, 1'b1, 8'h00);
    bus(tlic_adr_timer2_mode_reg, 1'b1, 8'h00);
    k = $urandom_range(3, 0);
    ext_req_pin25_n <= ~(4'h1 << k);
    repeat (12) @(posedge hclk);
    rd(tlic_adr_ext_flag_reg, 8'hf0, 8'h10 << k);
    bus(tlic_adr_ext_flag_reg, 1'b1, 8'h00);
    ext_req_pin25_n <= 4'hf;
    repeat (12) @(posedge hclk);
    rd(tlic_adr_ext_flag_reg, 8'hf0, 8'h00);
    $display("test pins done");
    results();
  end
endmodule // two_level_vectored_irq_controller_tb_top
